// [common/usb_cfg_pkg.sv]
// package: register map, field layout and timing counts for the usb configuration block
package usb_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h0c;
  localparam logic [7:0] ADDR_CORE_RESET = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // global configuration fields
  // ----------------------------------------------------------------
  localparam int TA_LSB = 10;
  localparam int TA_MSB = 13;
  localparam int HNP_BIT = 9;
  localparam int SRP_BIT = 8;
  localparam int TO_LSB = 0;
  localparam int TO_MSB = 2;
  localparam int FORCE_HOST_BIT = 29;
  localparam int FORCE_DEVICE_BIT = 30;
  localparam logic [31:0] CFG_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h6000_3f07;

  // ----------------------------------------------------------------
  // core reset control and status
  // ----------------------------------------------------------------
  localparam logic [31:0] CORE_RESET_VALUE = 32'h8000_0000;
  localparam logic [3:0] FULL_WORD_STRB = 4'hf;
  localparam int ST_HOST_BIT = 0;
  localparam int ST_PHASE_LSB = 1;
  localparam int ST_ID_BIT = 3;
  localparam int ST_BUSY_BIT = 4;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ACLK_HZ = 10_000_000;
  localparam int ACLK_PERIOD_NS = 1_000_000_000 / ACLK_HZ;
  localparam int PHY_CLOCK_HZ = 48_000_000;
  localparam int TIMEOUT_BASE_NS = 1500;
  localparam int TIMEOUT_BASE_CYCLES = TIMEOUT_BASE_NS / ACLK_PERIOD_NS;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------
  // link phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_TURN = 2'b01,
    PH_WAIT = 2'b11
  } phase_type;

endpackage

// [common/timer_if.sv]
// interface: load and expiry handshake between the phase logic and the cycle timer
interface timer_if;
  logic load;
  logic [usb_cfg_pkg::CNT_W-1:0] count;
  logic expired;
  logic busy;
  modport ctrl (output load, output count, input expired, input busy);
  modport tmr (input load, input count, output expired, output busy);
endinterface

// [core/pin_sync.sv]
// module: three-stage pin synchroniser, output follows once stages two and three agree
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pin and result
  input wire logic pin,
  output logic level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  wire agree = (s2_ff == s3_ff);
  wire nxt_level = agree ? s3_ff : level_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      level_ff <= RESET_VAL;
    end
    else if (ce)
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

  a_sync_agree: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(level_ff) |-> $past(s2_ff == s3_ff) && $past(ce))
    else $error("synchronised level changed without stage agreement");

endmodule

// [core/cycle_timer.sv]
// module: down counter that pulses expired a loaded number of cycles after load
module cycle_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  timer_if.tmr port_t
);

  logic [usb_cfg_pkg::CNT_W-1:0] cnt_ff;
  logic busy_ff;
  wire last = busy_ff && (cnt_ff == usb_cfg_pkg::CNT_W'(1));
  wire [usb_cfg_pkg::CNT_W-1:0] load_val = (port_t.count == '0) ? usb_cfg_pkg::CNT_W'(1) : port_t.count;
  wire [usb_cfg_pkg::CNT_W-1:0] nxt_cnt = port_t.load ? load_val : (busy_ff ? cnt_ff - 1'b1 : cnt_ff);
  wire nxt_busy = port_t.load || (busy_ff && !last);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end
    else if (ce)
    begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign port_t.expired = last;
  assign port_t.busy = busy_ff;

endmodule

// [core/usb_cfg_core.sv]
// module: global configuration fields, core reset control and packet turnaround/timeout timing
//
// Our own choice: register access over AXI4-Lite.
module usb_cfg_core (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [usb_cfg_pkg::ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [usb_cfg_pkg::ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // link pins
  input wire logic id_pin,
  input wire logic rx_eop_pin,
  input wire logic rx_start_pin,
  // link strobes and modes
  output logic tx_go,
  output logic pkt_timeout,
  output logic host_mode,
  output logic role_negotiation_enable,
  output logic session_request_enable
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [usb_cfg_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    addr_hit = (a[usb_cfg_pkg::ADDR_W-1:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[8*i +: 8] = nw[8*i +: 8];
    end
    strb_merge = m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [usb_cfg_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] cfg_ff;
  usb_cfg_pkg::phase_type phase_ff;
  usb_cfg_pkg::phase_type nxt_phase;
  logic eop_prev_ff;
  logic start_prev_ff;
  logic id_s;
  logic eop_s;
  logic start_s;
  timer_if t ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.RESET_VAL(1'b1)) u_id_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(id_pin),
    .level(id_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_eop_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(rx_eop_pin),
    .level(eop_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_start_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(rx_start_pin),
    .level(start_s)
  );

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign awready = ce && !aw_held_ff && !bvalid_ff;
  assign wready = ce && !w_held_ff && !bvalid_ff;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_do = ce && aw_held_ff && w_held_ff && !bvalid_ff;
  wire wr_cfg = addr_hit(awaddr_ff, usb_cfg_pkg::ADDR_GLOBAL_CFG);
  wire wr_rst = addr_hit(awaddr_ff, usb_cfg_pkg::ADDR_CORE_RESET);
  wire wr_stat = addr_hit(awaddr_ff, usb_cfg_pkg::ADDR_STATUS);
  wire wr_part_rst = wr_rst && (wstrb_ff != usb_cfg_pkg::FULL_WORD_STRB);
  wire wr_err = !(wr_cfg || wr_rst || wr_stat) || wr_part_rst;
  wire [1:0] nxt_bresp = wr_err ? usb_cfg_pkg::RESP_SLVERR : usb_cfg_pkg::RESP_OKAY;
  wire cfg_we = wr_do && wr_cfg;
  wire [31:0] cfg_merged = strb_merge(cfg_ff, wdata_ff, wstrb_ff);
  wire [31:0] nxt_cfg = (cfg_merged & usb_cfg_pkg::CFG_WRITE_MASK)
                      | (usb_cfg_pkg::CFG_RESET_VALUE & ~usb_cfg_pkg::CFG_WRITE_MASK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= usb_cfg_pkg::RESP_OKAY;
      cfg_ff <= usb_cfg_pkg::CFG_RESET_VALUE;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_do)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
      end
      else if (bvalid_ff && bready)
        bvalid_ff <= 1'b0;
      if (cfg_we)
        cfg_ff <= nxt_cfg;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [3:0] turnaround_cycles = cfg_ff[usb_cfg_pkg::TA_MSB:usb_cfg_pkg::TA_LSB];
  wire [2:0] timeout_extra_cycles = cfg_ff[usb_cfg_pkg::TO_MSB:usb_cfg_pkg::TO_LSB];
  wire force_host_role = cfg_ff[usb_cfg_pkg::FORCE_HOST_BIT];
  wire force_device_role = cfg_ff[usb_cfg_pkg::FORCE_DEVICE_BIT];
  assign host_mode = !force_device_role && (force_host_role || !id_s);
  assign role_negotiation_enable = cfg_ff[usb_cfg_pkg::HNP_BIT];
  assign session_request_enable = cfg_ff[usb_cfg_pkg::SRP_BIT];

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign arready = ce && !rvalid_ff;
  wire ar_take = arvalid && arready;
  wire rd_cfg = addr_hit(araddr, usb_cfg_pkg::ADDR_GLOBAL_CFG);
  wire rd_rst = addr_hit(araddr, usb_cfg_pkg::ADDR_CORE_RESET);
  wire rd_stat = addr_hit(araddr, usb_cfg_pkg::ADDR_STATUS);
  wire [31:0] status_word = {27'h0, t.busy, id_s, phase_ff, host_mode};
  wire [31:0] rd_word = rd_cfg ? cfg_ff
                      : rd_rst ? usb_cfg_pkg::CORE_RESET_VALUE
                      : rd_stat ? status_word
                      : 32'h0000_0000;
  wire [1:0] rd_resp = (rd_cfg || rd_rst || rd_stat) ? usb_cfg_pkg::RESP_OKAY : usb_cfg_pkg::RESP_SLVERR;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= usb_cfg_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_resp;
      end
      else if (rvalid_ff && rready)
        rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ----------------------------------------------------------------
  // turnaround and timeout sequencing
  // ----------------------------------------------------------------
  wire eop_rise = eop_s && !eop_prev_ff;
  wire start_rise = start_s && !start_prev_ff;
  wire [usb_cfg_pkg::CNT_W-1:0] turn_count = host_mode ? usb_cfg_pkg::CNT_W'(1)
                                           : usb_cfg_pkg::CNT_W'(turnaround_cycles);
  wire [usb_cfg_pkg::CNT_W-1:0] wait_count = usb_cfg_pkg::CNT_W'(usb_cfg_pkg::TIMEOUT_BASE_CYCLES)
                                           + usb_cfg_pkg::CNT_W'(timeout_extra_cycles);
  wire turn_done = (phase_ff == usb_cfg_pkg::PH_TURN) && t.expired && ce;
  wire wait_done = (phase_ff == usb_cfg_pkg::PH_WAIT) && t.expired && !start_rise && ce;
  wire idle_go = (phase_ff == usb_cfg_pkg::PH_IDLE) && eop_rise && ce;

  assign t.load = idle_go || turn_done;
  assign t.count = idle_go ? turn_count : wait_count;
  assign tx_go = turn_done;
  assign pkt_timeout = wait_done;

  always_comb
  begin
    case (phase_ff)
      usb_cfg_pkg::PH_IDLE: nxt_phase = eop_rise ? usb_cfg_pkg::PH_TURN : usb_cfg_pkg::PH_IDLE;
      usb_cfg_pkg::PH_TURN: nxt_phase = t.expired ? usb_cfg_pkg::PH_WAIT : usb_cfg_pkg::PH_TURN;
      usb_cfg_pkg::PH_WAIT: nxt_phase = (start_rise || t.expired) ? usb_cfg_pkg::PH_IDLE : usb_cfg_pkg::PH_WAIT;
      default: nxt_phase = usb_cfg_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_ff <= usb_cfg_pkg::PH_IDLE;
      eop_prev_ff <= 1'b0;
      start_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      phase_ff <= nxt_phase;
      eop_prev_ff <= eop_s;
      start_prev_ff <= start_s;
    end
  end

  cycle_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .port_t(t.tmr)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] elapsed_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      elapsed_ff <= 6'h00;
    else if (ce)
      elapsed_ff <= t.load ? 6'h01 : ((elapsed_ff == 6'h3f) ? elapsed_ff : elapsed_ff + 6'h01);
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_turn_device_len: assert property (
    tx_go && !host_mode && $stable(cfg_ff) |-> elapsed_ff == ((turnaround_cycles == 4'h0) ? 6'h01 : 6'(turnaround_cycles)))
    else $error("device turnaround length differs from the turnaround field");

  a_turn_host_one: assert property (
    tx_go && host_mode && $stable(host_mode) |-> elapsed_ff == 6'h01)
    else $error("host mode turnaround is not one cycle");

  a_hnp_write: assert property (
    cfg_we && wstrb_ff[1] |=> role_negotiation_enable == $past(wdata_ff[usb_cfg_pkg::HNP_BIT]))
    else $error("role negotiation enable did not follow its bit");

  a_srp_write: assert property (
    cfg_we && wstrb_ff[1] |=> session_request_enable == $past(wdata_ff[usb_cfg_pkg::SRP_BIT]))
    else $error("session request enable did not follow its bit");

  a_timeout_len: assert property (
    pkt_timeout && $stable(cfg_ff) |-> elapsed_ff == 6'(usb_cfg_pkg::TIMEOUT_BASE_CYCLES) + 6'(timeout_extra_cycles))
    else $error("packet timeout length differs from base plus extra");

  a_reset_read: assert property (
    ar_take && rd_rst |=> rvalid && rdata == usb_cfg_pkg::CORE_RESET_VALUE && rresp == usb_cfg_pkg::RESP_OKAY)
    else $error("core reset control did not read its reset value");

  a_word_only: assert property (
    wr_do && wr_part_rst |=> bvalid && bresp == usb_cfg_pkg::RESP_SLVERR)
    else $error("partial write to core reset control was not refused");

  a_turn_to_wait: assert property (
    tx_go |=> phase_ff == usb_cfg_pkg::PH_WAIT && t.busy)
    else $error("timeout wait did not start after turnaround");

  c_turnaround: cover property (tx_go && !host_mode && turnaround_cycles > 4'h2);
  c_timeout: cover property (pkt_timeout && timeout_extra_cycles == 3'h7);
  c_reply: cover property (phase_ff == usb_cfg_pkg::PH_WAIT && start_rise);
  c_refused: cover property (bvalid && bresp == usb_cfg_pkg::RESP_SLVERR);

endmodule

// [verification/usb_peer_model.sv]
// usb peer model: drives the id, end-of-packet and reply-start pins
module usb_peer_model (
  // clock
  input wire logic aclk,
  // commands from the bench
  input wire logic send_pkt,
  input wire logic reply_en,
  input wire logic [2:0] reply_gap,
  input wire logic id_level,
  // link side
  input wire logic tx_go,
  output logic id_pin,
  output logic rx_eop_pin,
  output logic rx_start_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int eop_cnt = 0;
  int gap_cnt = 0;
  int start_cnt = 0;

  // end-of-packet and reply-start pins held six cycles so the synchroniser sees them
  assign id_pin = id_level;
  assign rx_eop_pin = eop_cnt != 0;
  assign rx_start_pin = start_cnt != 0;

  always @(posedge aclk)
  begin
    if (send_pkt)
      eop_cnt <= 6;
    else if (eop_cnt != 0)
      eop_cnt <= eop_cnt - 1;
    if (tx_go && reply_en)
      gap_cnt <= int'(reply_gap) + 1;
    else if (gap_cnt != 0)
      gap_cnt <= gap_cnt - 1;
    if (gap_cnt == 1)
      start_cnt <= 6;
    else if (start_cnt != 0)
      start_cnt <= start_cnt - 1;
  end
endmodule

// [verification/usb_cfg_core_bench.sv]
// testbench: register bus, role selection and turnaround/timeout timing
module usb_cfg_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd, cfg;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rsp;
  logic id_pin, rx_eop_pin, rx_start_pin, tx_go, pkt_timeout, host_mode, hnp_en, srp_en;
  logic send_pkt = 1'b0, reply_en = 1'b0, id_level = 1'b1, ce = 1'b1;
  logic [2:0] reply_gap = 3'h0;
  int err_count = 0;
  int check_count = 0;
  int ta_n, to_n;

  always #50 aclk = ~aclk;

  usb_cfg_core usb_cfg_core_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .id_pin(id_pin), .rx_eop_pin(rx_eop_pin),
    .rx_start_pin(rx_start_pin), .tx_go(tx_go), .pkt_timeout(pkt_timeout), .host_mode(host_mode),
    .role_negotiation_enable(hnp_en), .session_request_enable(srp_en));

  usb_peer_model usb_peer_model_i (.aclk(aclk), .send_pkt(send_pkt), .reply_en(reply_en),
    .reply_gap(reply_gap), .id_level(id_level), .tx_go(tx_go), .id_pin(id_pin),
    .rx_eop_pin(rx_eop_pin), .rx_start_pin(rx_start_pin));

  // ----------------------------------------------------------------
  // checking and expectations
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int exp_ta(input logic [31:0] c, input logic host);
    if (host || c[13:10] == 4'h0)
      return 1;
    return int'(c[13:10]);
  endfunction

  function automatic int exp_to(input logic [31:0] c);
    return usb_cfg_pkg::TIMEOUT_BASE_CYCLES + int'(c[2:0]);
  endfunction

  task automatic print_verdict;
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus and link tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    while (!(aw_ok && w_ok))
    begin
      @(negedge aclk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      @(posedge aclk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      rsp = bresp;
    end
    while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do
      @(negedge aclk);
    while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do
      @(negedge aclk);
    while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic run_pkt(input logic reply);
    ta_n = 0;
    to_n = 0;
    reply_en <= reply;
    reply_gap <= 3'($urandom_range(5, 0));
    send_pkt <= 1'b1;
    @(posedge aclk);
    send_pkt <= 1'b0;
    do
    begin
      @(negedge aclk);
      ta_n++;
    end
    while (tx_go !== 1'b1 && ta_n < 40);
    for (int i = 1; i <= 40; i++)
    begin
      @(negedge aclk);
      if (pkt_timeout === 1'b1 && to_n == 0)
        to_n = i;
    end
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h5ae7));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(usb_cfg_pkg::ADDR_CORE_RESET);
    chk(rd, usb_cfg_pkg::CORE_RESET_VALUE);
    axi_read(usb_cfg_pkg::ADDR_GLOBAL_CFG);
    chk(rd, 32'h0000_0000);
    chk({31'h0, host_mode}, 32'h0000_0000);
    axi_write(usb_cfg_pkg::ADDR_CORE_RESET, 32'h0000_0000, 4'h3);
    chk({30'h0, rsp}, {30'h0, usb_cfg_pkg::RESP_SLVERR});
    axi_write(usb_cfg_pkg::ADDR_CORE_RESET, 32'h0000_0000, 4'hf);
    chk({30'h0, rsp}, {30'h0, usb_cfg_pkg::RESP_OKAY});
    axi_read(usb_cfg_pkg::ADDR_CORE_RESET);
    chk(rd, 32'h8000_0000);
    axi_read(8'h40);
    chk({rsp, rd[29:0]}, {usb_cfg_pkg::RESP_SLVERR, 30'h0});
    axi_write(8'h44, 32'h0000_0001, 4'hf);
    chk({30'h0, rsp}, {30'h0, usb_cfg_pkg::RESP_SLVERR});
    for (int k = 0; k < 8; k++)
    begin
      cfg = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'h0000_3f07 : $urandom & 32'h0000_3f07;
      axi_write(usb_cfg_pkg::ADDR_GLOBAL_CFG, cfg, 4'hf);
      axi_read(usb_cfg_pkg::ADDR_GLOBAL_CFG);
      chk(rd, cfg);
      chk({31'h0, hnp_en}, {31'h0, cfg[9]});
      chk({31'h0, srp_en}, {31'h0, cfg[8]});
      run_pkt(k[0]);
      chk(32'(ta_n), 32'(5 + exp_ta(cfg, 1'b0)));
      chk(32'(to_n), k[0] ? 32'h0 : 32'(exp_to(cfg)));
    end
    axi_write(usb_cfg_pkg::ADDR_GLOBAL_CFG, 32'h0000_3c05, 4'h1);
    axi_read(usb_cfg_pkg::ADDR_GLOBAL_CFG);
    cfg = {cfg[31:8], 8'h05};
    chk(rd, cfg);
    id_level <= 1'b0;
    ce <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, host_mode}, 32'h0000_0000);
    repeat (6) @(posedge aclk);
    chk({29'h0, host_mode, awready, arready}, 32'h0000_0000);
    ce <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h0000_0001);
    run_pkt(1'b0);
    chk(32'(ta_n), 32'(5 + exp_ta(cfg, 1'b1)));
    chk(32'(to_n), 32'(exp_to(cfg)));
    axi_read(usb_cfg_pkg::ADDR_STATUS);
    chk({31'h0, rd[0]}, 32'h0000_0001);
    id_level <= 1'b1;
    axi_write(usb_cfg_pkg::ADDR_GLOBAL_CFG, 32'h2000_0000, 4'hf);
    repeat (8) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h0000_0001);
    axi_write(usb_cfg_pkg::ADDR_GLOBAL_CFG, 32'h6000_0000, 4'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h0000_0000);
    print_verdict();
  end
endmodule
